// [flash_fetch_ecc_prefetch.sv]
/*
 * flash read path: demand reads, one-word prefetch, ecc and error limit.
 * assumes the flash array holds flash_code valid on the last cycle of an
 * access of wait_states+1 cycles with flash_addr held; one request at a time.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_fetch_ecc_prefetch
    import flash_fetch_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int WS_W   = 4,
    parameter int CNT_W  = 16
)
(
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              req_valid,
    input  wire logic              req_fetch,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              fast_branch_insn,
    output logic                   req_ready,
    output rsp_t                   rsp,
    output logic                   sbe_irq,
    output logic                   sbe_fetch,
    output logic                   flash_req,
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [CODE_W-1:0] flash_code,
    input  wire logic [WS_W-1:0]   wait_states,
    input  wire logic              prefetch_en,
    input  wire logic              limit_wr,
    input  wire logic [CNT_W-1:0]  limit_wdata
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    state_t             state;
    logic [ADDR_W-1:0]  want_addr;
    logic               want_fetch;
    logic [WS_W-1:0]    acc_cnt;
    logic               acc_pf;
    logic               pf_valid;
    logic [ADDR_W-1:0]  pf_addr;
    ecc_result_t        pf_res;
    ecc_result_t        ecc_res;
    logic [CNT_W-1:0]   err_cnt;
    logic [CNT_W-1:0]   err_limit;

    flash_ecc_check u_ecc (
        .code   (flash_code),
        .result (ecc_res)
    );

    // ---------------------------------------------------------------
    // decisions
    // ---------------------------------------------------------------
    logic              take;
    logic              seq_ok;
    logic              acc_done;
    logic              buf_hit;
    logic              live_hit;
    logic              fly_hit;
    logic              hit;
    logic              miss;
    logic              done_demand;
    logic              deliver;
    ecc_result_t       dres;
    logic              dfetch;
    logic [ADDR_W-1:0] daddr;
    logic              start_pf;
    state_t            next_state;

    always_comb
    begin
        take        = req_valid && req_ready;
        // a fast branch never trusts the speculative word
        seq_ok      = req_fetch && !fast_branch_insn;   // see RL9
        acc_done    = flash_req && acc_cnt == '0;
        buf_hit     = seq_ok && pf_valid && pf_addr == req_addr;
        live_hit    = seq_ok && acc_done && acc_pf && flash_addr == req_addr;
        // an in-flight prefetch is adopted, so the wait is only what is left
        fly_hit     = seq_ok && flash_req && acc_pf && acc_cnt != '0
                      && flash_addr == req_addr;   // see RL7 RL8
        hit         = take && (buf_hit || live_hit);
        miss        = take && !buf_hit && !live_hit && !fly_hit;
        done_demand = state == ST_WAIT && acc_done;
        deliver     = hit || done_demand;
        dres        = (hit && buf_hit) ? pf_res : ecc_res;
        dfetch      = hit ? 1'b1 : want_fetch;
        daddr       = hit ? req_addr : want_addr;
        // no speculation past a flawed fetch: the refetch starts clean
        start_pf    = deliver && dfetch && prefetch_en && !dres.sbe;   // see RL2 RL4
        next_state  = state;
        case (state)
            ST_IDLE: if (take && !hit) next_state = ST_WAIT;
            ST_WAIT: if (done_demand)  next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // request side
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state      <= ST_IDLE;
            req_ready  <= 1'b0;
            want_addr  <= '0;
            want_fetch <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            req_ready <= next_state == ST_IDLE;
            if (take)
            begin
                want_addr  <= req_addr;
                want_fetch <= req_fetch;
            end
        end
    end

    // ---------------------------------------------------------------
    // flash access engine
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            flash_req  <= 1'b0;
            flash_addr <= '0;
            acc_cnt    <= '0;
            acc_pf     <= 1'b0;
        end
        else if (miss)
        begin
            // a miss aborts speculation; the access lasts exactly wait_states+1 cycles
            flash_req  <= 1'b1;
            flash_addr <= req_addr;
            acc_cnt    <= wait_states;   // see RL7 RL8 RL9
            acc_pf     <= 1'b0;
        end
        else if (take && fly_hit)
        begin
            // the adopting edge still counts down, or it costs a stall cycle
            acc_pf  <= 1'b0;
            acc_cnt <= acc_cnt - 1'b1;   // see RL7 RL8
        end
        else if (start_pf)
        begin
            flash_req  <= 1'b1;
            flash_addr <= daddr + 1'b1;
            acc_cnt    <= wait_states;
            acc_pf     <= 1'b1;
        end
        else if (acc_done)
            flash_req <= 1'b0;
        else if (flash_req)
            acc_cnt <= acc_cnt - 1'b1;
    end

    // ---------------------------------------------------------------
    // prefetch buffer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pf_valid <= 1'b0;
            pf_addr  <= '0;
            pf_res   <= '0;
        end
        else if (take && req_fetch && fast_branch_insn)
            pf_valid <= 1'b0;   // see RL9
        else if (hit && buf_hit)
            pf_valid <= 1'b0;
        else if (deliver && dfetch && dres.sbe)
            pf_valid <= 1'b0;   // see RL2
        else if (acc_done && acc_pf && !hit)
        begin
            pf_valid <= 1'b1;
            pf_addr  <= flash_addr;
            pf_res   <= ecc_res;
        end
    end

    // ---------------------------------------------------------------
    // response
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rsp <= '0;
        else
        begin
            rsp.valid <= deliver;
            if (deliver)
            begin
                rsp.fetch <= dfetch;
                rsp.sbe   <= dres.sbe;
                rsp.dbe   <= dres.dbe;
                rsp.data  <= dres.data;   // see RL10
            end
        end
    end

    // ---------------------------------------------------------------
    // error limit and interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            err_limit <= CNT_W'(LIMIT_RST);   // see RL5
        else if (limit_wr)
            err_limit <= limit_wdata;
    end

    // limit 0 fires on every error, so a flawed fetch loops forever
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            err_cnt   <= '0;
            sbe_irq   <= 1'b0;
            sbe_fetch <= 1'b0;
        end
        else
        begin
            sbe_irq <= 1'b0;
            if (deliver && dres.sbe)
            begin
                if (err_cnt >= err_limit)
                begin
                    sbe_irq   <= 1'b1;   // see RL1 RL3
                    sbe_fetch <= dfetch;   // see RL4
                    err_cnt   <= '0;
                end
                else
                    err_cnt <= err_cnt + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [WS_W:0] wait_cyc;
    logic [WS_W:0] ws_seen;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_cyc <= '0;
            ws_seen  <= '0;
        end
        else
        begin
            wait_cyc <= (state == ST_WAIT) ? wait_cyc + 1'b1 : '0;
            if (take)
                ws_seen <= {1'b0, wait_states};
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence sbe_seen;
        deliver && dres.sbe;
    endsequence

    sequence fetch_sbe_seen;
        deliver && dres.sbe && dfetch;
    endsequence

    chk_irq_every_error: assert property (   // see RL1 RL3
        sbe_seen ##0 (err_limit == '0) |=> sbe_irq && sbe_fetch == $past(dfetch))
        else $error("single-bit error with zero limit gave no interrupt");
    chk_limit_reset: assert property (   // see RL5
        $rose(nrst) |-> err_limit == '0 ##1 (limit_wr || $stable(err_limit)))
        else $error("error limit not zero after reset");
    chk_refetch_clean: assert property (   // see RL2
        fetch_sbe_seen |=> !pf_valid && !flash_req ##0 req_ready)
        else $error("flawed fetch left speculative state behind");
    chk_data_keeps_pf: assert property (   // see RL4
        deliver && !dfetch && dres.sbe && pf_valid |=> pf_valid && !$past(start_pf))
        else $error("data read error disturbed the prefetch path");
    chk_miss_no_stall: assert property (   // see RL7 RL8
        state == ST_WAIT |-> wait_cyc <= ws_seen)
        else $error("fetch waited longer than the wait states");
    chk_hit_one_cycle: assert property (   // see RL8
        hit |=> rsp.valid && rsp.fetch && req_ready)
        else $error("prefetch hit not answered next cycle");
    chk_fast_branch_flush: assert property (   // see RL9
        take && req_fetch && fast_branch_insn |=> !pf_valid && !acc_pf
        && flash_addr == $past(req_addr))
        else $error("fast branch served from speculative word");
    chk_corrected_word: assert property (   // see RL10
        sbe_seen |=> rsp.valid && rsp.sbe && rsp.data == $past(dres.data))
        else $error("corrected word not delivered");

endmodule : flash_fetch_ecc_prefetch

`default_nettype wire

// [flash_fetch_pkg.sv]
/*
 * shared constants, carrier structs and state codes for the flash read path.
 * assumes a 39-bit stored codeword: bit 0 overall parity, bits 1..38 hamming.
 */
// What this block does
// RL1: a corrected single-bit flash error raises the single-bit-error interrupt
// RL2: after the handler, the faulting instruction is fetched from flash again normally
// RL3: error limit 0 means every repeated single-bit error interrupts again
// RL4: only instruction fetch errors lead to the refetch loop, never data reads
// RL5: error limit comes out of reset at zero
// RL6: software sets error limit to one or more before trusting the interrupt
// RL7: three wait states with prefetch on add no extra one-cycle stall
// RL8: one or two wait states with prefetch on add no extra stall
// RL9: fast-branch instructions are delivered correctly through the prefetch path
// RL10: a single-bit error still returns the corrected word to the requester
`default_nettype none

package flash_fetch_pkg;

    // ---------------------------------------------------------------
    // widths and reset values
    // ---------------------------------------------------------------
    localparam int          DATA_W    = 32;
    localparam int          CODE_W    = 39;
    localparam int          SYN_W     = 6;
    localparam int unsigned LIMIT_RST = 0;

    // ---------------------------------------------------------------
    // carriers and states
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              sbe;
        logic              dbe;
    } ecc_result_t;

    typedef struct packed {
        logic              valid;
        logic              fetch;
        logic              sbe;
        logic              dbe;
        logic [DATA_W-1:0] data;
    } rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } state_t;

endpackage : flash_fetch_pkg

`default_nettype wire

// [flash_ecc_check.sv]
/*
 * single-error-correct, double-error-detect check of one flash codeword.
 * assumes the codeword layout of the package; purely combinational.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_ecc_check
    import flash_fetch_pkg::*;
(
    input  wire logic [CODE_W-1:0] code,
    output ecc_result_t            result
);

    function automatic logic is_check_pos(input int pos);
        return (pos & (pos - 1)) == 0;
    endfunction : is_check_pos

    logic [SYN_W-1:0]  syn;
    logic              par;
    logic [CODE_W-1:0] fixed;

    always_comb
    begin
        int k;
        k     = 0;
        syn   = '0;
        for (int i = 1; i < CODE_W; i++)
        begin
            if (code[i])
                syn = syn ^ SYN_W'(i);
        end
        par   = ^code;
        fixed = code;
        // syndrome 0 with bad parity is the parity bit itself, data is clean
        if (par && syn != '0 && int'(syn) < CODE_W)
            fixed[syn] = ~fixed[syn];   // see RL10
        result.data = '0;
        for (int i = 3; i < CODE_W; i++)
        begin
            if (!is_check_pos(i))
            begin
                result.data[k] = fixed[i];
                k = k + 1;
            end
        end
        result.sbe = par && int'(syn) < CODE_W;   // see RL1
        result.dbe = (!par && syn != '0) || (par && int'(syn) >= CODE_W);
    end

endmodule : flash_ecc_check

`default_nettype wire

// [flash_array_model.sv]
/*
 * flash array model: each word holds a pattern made from its address,
 * stored as a secded codeword, with one bit flipped on demand.
 * assumes flash_addr is held steady while flash_req is high.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_array_model
    import flash_fetch_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    input  wire logic              clk_sys,
    input  wire logic              flash_req,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic              err_en,
    input  wire logic [ADDR_W-1:0] err_addr,
    input  wire logic [5:0]        err_bit,
    output logic [CODE_W-1:0]      flash_code
);
    logic [CODE_W-1:0] last = '0;

    function automatic logic [CODE_W-1:0] encode(input logic [DATA_W-1:0] d);
        logic [CODE_W-1:0] c;
        int                k;
        c = '0;
        k = 0;
        for (int i = 3; i < CODE_W; i++)
            if ((i & (i - 1)) != 0)
            begin
                c[i] = d[k];
                k++;
            end
        for (int p = 1; p < CODE_W; p = p * 2)
            for (int i = p + 1; i < CODE_W; i++)
                if ((i & p) != 0)
                    c[p] ^= c[i];
        c[0] = ^c;
        return c;
    endfunction : encode

    // outside an access the bus shows the inverse of the last word, never stale data
    always_comb
    begin
        if (flash_req)
        begin
            flash_code = encode(DATA_W'({12'ha5a, flash_addr}));
            if (err_en && flash_addr == err_addr)
                flash_code[err_bit] = ~flash_code[err_bit];
        end
        else
            flash_code = ~last;
    end

    always_ff @(posedge clk_sys)
        if (flash_req)
            last <= flash_code;

endmodule : flash_array_model

`default_nettype wire

// [tb.sv]
/*
 * self-checking bench for the flash read path: timing, ecc, error limit.
 * assumes the flash array model beside it and a 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none

module tb
    import flash_fetch_pkg::*;
;
    logic              clk_sys = 0, nrst = 0, req_valid = 0, req_fetch = 0;
    logic              fast_branch_insn = 0, prefetch_en = 1, limit_wr = 0, err_en = 0;
    logic [19:0]       req_addr = '0, err_addr = 20'h0a000;
    logic [3:0]        wait_states = 4'h2;
    logic [15:0]       limit_wdata = '0;
    logic [5:0]        err_bit = '0;
    logic              req_ready, sbe_irq, sbe_fetch, flash_req, irq, sf;
    logic [19:0]       flash_addr;
    logic [CODE_W-1:0] flash_code;
    rsp_t              rsp, r;
    int                err_count = 0, num_checks = 0, lat;

    flash_fetch_ecc_prefetch flash_fetch_ecc_prefetch_inst (.clk_sys(clk_sys), .nrst(nrst),
        .req_valid(req_valid), .req_fetch(req_fetch), .req_addr(req_addr),
        .fast_branch_insn(fast_branch_insn), .req_ready(req_ready), .rsp(rsp),
        .sbe_irq(sbe_irq), .sbe_fetch(sbe_fetch), .flash_req(flash_req),
        .flash_addr(flash_addr), .flash_code(flash_code), .wait_states(wait_states),
        .prefetch_en(prefetch_en), .limit_wr(limit_wr), .limit_wdata(limit_wdata));

    flash_array_model flash_array_model_inst (.clk_sys(clk_sys), .flash_req(flash_req),
        .flash_addr(flash_addr), .err_en(err_en), .err_addr(err_addr),
        .err_bit(err_bit), .flash_code(flash_code));

    always #5 clk_sys = ~clk_sys;

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_lat(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_lat

    // request held until the taking edge; latency counted in cycles from it
    task automatic do_req(input logic f, input logic [19:0] a, input logic fb);
        int n;
        n = 0;
        // one edge between calls, so no strobe is set twice in a time step
        tick();
        while (req_ready !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        chk_bit(req_ready, 1'b1);
        req_valid = 1'b1;
        req_fetch = f;
        req_addr = a;
        fast_branch_insn = fb;
        lat = 0;
        do
        begin
            tick();
            lat++;
            req_valid = 1'b0;
            fast_branch_insn = 1'b0;
        end while (rsp.valid !== 1'b1 && lat < 40);
        r = rsp;
        irq = sbe_irq;
        sf = sbe_fetch;
    endtask : do_req

    task automatic chk_rsp(input logic [19:0] a, input logic s, input logic i, input int l);
        chk_word(r.data, {12'ha5a, a});
        chk_bit(r.sbe, s);
        chk_bit(r.dbe, 1'b0);
        chk_bit(irq, i);
        chk_lat(lat, l);
    endtask : chk_rsp

    task automatic t_timing;
        for (int ws = 1; ws <= 3; ws++)
        begin
            repeat (6) tick();
            wait_states = 4'(ws);
            do_req(1'b1, 20'(ws * 256), 1'b0);
            chk_rsp(20'(ws * 256), 1'b0, 1'b0, ws + 2);
            // eight hits in a row: any hidden stall shows as latency above one
            for (int k = 1; k <= 8; k++)
            begin
                repeat (ws + 3) tick();
                do_req(1'b1, 20'(ws * 256 + k), 1'b0);
                chk_rsp(20'(ws * 256 + k), 1'b0, 1'b0, 1);
            end
            // taken two cycles into a running prefetch: only its own wait remains
            do_req(1'b1, 20'(ws * 256 + 9), 1'b0);
            chk_rsp(20'(ws * 256 + 9), 1'b0, 1'b0, ws);
        end
        $display("test timing done");
    endtask : t_timing

    task automatic t_sbe_fetch;
        logic [5:0] flip [3] = '{6'h00, 6'h04, 6'h14};
        repeat (6) tick();
        wait_states = 4'h2;
        err_en = 1'b1;
        // overall parity, a check bit and a data bit in turn
        foreach (flip[i])
        begin
            err_bit = flip[i];
            do_req(1'b1, err_addr, 1'b0);
            chk_rsp(err_addr, 1'b1, 1'b1, 4);
            chk_bit(sf, 1'b1);
            chk_bit(r.fetch, 1'b1);
        end
        $display("test sbe fetch done");
    endtask : t_sbe_fetch

    task automatic t_sbe_data;
        do_req(1'b1, 20'h0b000, 1'b0);
        repeat (5) tick();
        do_req(1'b0, err_addr, 1'b0);
        chk_rsp(err_addr, 1'b1, 1'b1, 4);
        chk_bit(sf, 1'b0);
        chk_bit(r.fetch, 1'b0);
        do_req(1'b1, 20'h0b001, 1'b0);
        chk_rsp(20'h0b001, 1'b0, 1'b0, 1);
        $display("test sbe data done");
    endtask : t_sbe_data

    task automatic t_limit;
        limit_wr = 1'b1;
        limit_wdata = 16'h0001;
        tick();
        limit_wr = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            do_req(1'b1, err_addr, 1'b0);
            chk_rsp(err_addr, 1'b1, 1'(k), 4);
        end
        err_en = 1'b0;
        $display("test limit done");
    endtask : t_limit

    task automatic t_branch;
        do_req(1'b1, 20'h0c000, 1'b0);
        repeat (5) tick();
        do_req(1'b1, 20'h0c001, 1'b1);
        chk_rsp(20'h0c001, 1'b0, 1'b0, 4);
        do_req(1'b1, 20'h0c002, 1'b1);
        chk_word(r.data, 32'ha5a0c002);
        $display("test branch done");
    endtask : t_branch

    task automatic results;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial
    begin
        #20000;
        err_count++;
        results();
    end

    initial
    begin
        repeat (3) tick();
        chk_bit(req_ready, 1'b0);
        chk_bit(rsp.valid, 1'b0);
        nrst = 1'b1;
        repeat (2) tick();
        chk_bit(req_ready, 1'b1);
        t_timing();
        t_sbe_fetch();
        t_sbe_data();
        t_limit();
        t_branch();
        results();
    end

endmodule : tb

`default_nettype wire
